/* pm_ctrl_pkg.sv */
// constants for the power management control/status register bank
// Operation
// - control/status contents survive the internal D3hot-to-D0 reset.
// - D3hot-to-D0 resets other registers except wake context and global-only bits.
// - wake status bit 15 sets on every wake event, enable or not.
// - writing 1 clears wake status and drops wake; writing 0 does nothing.
// - wake status cleared by bus reset only while wake is disabled.
// - wake enable bit 8 gates assertion of the wake signal.
// - wake enable cleared only by global reset, not bus reset.
// - data scale and data select fields read zero.
// - reserved bits read zero in control/status and bridge extension registers.
// - power state bits 1-0 report and take state, 00 D0 to 11 D3hot.
// - bus power/clock control enable bit 7 reads one.
// - with control disabled, power state writes do not steer secondary bus.
// - bit 6 reads one; D3hot stops secondary clock, not power.
// - power data register always reads zero.
package pm_ctrl_pkg;
    localparam logic [7:0] CSR_LO_OFFSET = 8'hA4;
    localparam logic [7:0] CSR_HI_OFFSET = 8'hA5;
    localparam logic [7:0] BRIDGE_EXT_OFFSET = 8'hA6;
    localparam logic [7:0] PM_DATA_OFFSET = 8'hA7;
    localparam int WAKE_STATUS_POS = 15;
    localparam int WAKE_ENABLE_POS = 8;
    localparam int BUS_POWER_CLOCK_CTL_ENABLE_POS = 7;
    localparam int D3_ACTION_POS = 6;
    localparam logic [7:0] BRIDGE_EXT_VALUE = 8'hC0;
    localparam logic [7:0] PM_DATA_VALUE = 8'h00;
    typedef enum logic [1:0] {
        PS_D0 = 2'b00,
        PS_D1 = 2'b01,
        PS_D2 = 2'b10,
        PS_D3HOT = 2'b11
    } power_state_t;
endpackage

/* wake_status_cell.sv */
// wake event status flag with write-one-to-clear and split reset
`timescale 1ns/1ps
`default_nettype none
module wake_status_cell (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bus_reset_sync,
    input wire logic enable,
    input wire logic event_in,
    input wire logic clear_in,
    output logic status
);
    logic status_q;
    logic status_d;
    always_comb begin
        status_d = status_q;
        if (clear_in) begin
            status_d = 1'b0;
        end
        if (bus_reset_sync && !enable) begin
            status_d = 1'b0;
        end
        // set beats clear so a simultaneous event is never lost
        if (event_in) begin
            status_d = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= 1'b0;
        end else begin
            status_q <= status_d;
        end
    end
    assign status = status_q;
endmodule
`default_nettype wire

/* pm_ctrl_status.sv */
// configuration-space power management control/status registers
`timescale 1ns/1ps
`default_nettype none
module pm_ctrl_status
    import pm_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pci_bus_reset_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic wake_event,
    output logic [31:0] cfg_rdata,
    output logic wake_n,
    output logic [1:0] power_state,
    output logic sec_clock_stop,
    output logic sec_power_off,
    output logic d3hot_to_d0_reset
);
    import pm_ctrl_pkg::*;

    // rst_b is the global reset and clears everything here; the bus reset is a pin,
    // synchronised below, and only reaches the power state, the D3hot-to-D0 reset pulse and a disabled wake status

    logic pci_bus_reset_n_meta_q;
    logic pci_bus_reset_n_sync_q;
    logic bus_reset_act;

    // decoded config strobes
    logic word_hit;
    logic rd_hit;
    logic wr_lo;
    logic wr_hi;
    logic status_clear;

    // wake context
    logic wake_status;
    logic wake_en_q;
    logic wake_en_d;
    logic wake_n_q;
    logic wake_n_d;

    // power state, the secondary bus controls it steers and the D3hot-to-D0 reset pulse
    power_state_t ps_q;
    power_state_t ps_d;
    logic clk_stop_q;
    logic clk_stop_d;
    logic pwr_off_q;
    logic pwr_off_d;
    logic d0rst_q;
    logic d0rst_d;

    // read return path
    logic [15:0] csr_word;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // the power state lanes of a write, taken as an encoded state
    function automatic power_state_t lane_state(input logic [31:0] wdata);
        lane_state = power_state_t'(wdata[1:0]);
    endfunction

    // one secondary bus action for D3hot, picked by the fixed bridge bits;
    // with bus power/clock control off, the power state steers nothing
    function automatic logic d3_action(input power_state_t state, input logic stop_clock);
        d3_action = BRIDGE_EXT_VALUE[BUS_POWER_CLOCK_CTL_ENABLE_POS]
            && (BRIDGE_EXT_VALUE[D3_ACTION_POS] == stop_clock)
            && (state == PS_D3HOT);
    endfunction

    // upper half of the dword is fixed: data readout byte, then bridge extension byte
    function automatic logic [31:0] read_word(input logic [15:0] csr);
        read_word = {PM_DATA_VALUE, BRIDGE_EXT_VALUE, csr};
    endfunction

    // two flops before anything looks at the bus reset pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pci_bus_reset_n_meta_q <= 1'b0;
            pci_bus_reset_n_sync_q <= 1'b0;
        end else begin
            pci_bus_reset_n_meta_q <= ~pci_bus_reset_n;
            pci_bus_reset_n_sync_q <= pci_bus_reset_n_meta_q;
        end
    end
    assign bus_reset_act = pci_bus_reset_n_sync_q;

    // all four bytes share one dword at A4h; lanes 2 and 3 hold no writable bits
    assign word_hit = (cfg_addr[7:2] == CSR_LO_OFFSET[7:2]);
    assign rd_hit = cfg_rd && word_hit;
    assign wr_lo = cfg_wr && word_hit && cfg_be[0];
    assign wr_hi = cfg_wr && word_hit && cfg_be[1];
    assign status_clear = wr_hi && cfg_wdata[WAKE_STATUS_POS];

    // set-beats-clear and the split reset live in the status cell
    wake_status_cell u_wake_status (
        .clk(clk),
        .rst_b(rst_b),
        .bus_reset_sync(bus_reset_act),
        .enable(wake_en_q),
        .event_in(wake_event),
        .clear_in(status_clear),
        .status(wake_status)
    );

    // enable is a global-reset-only bit: the bus reset never reaches it
    always_comb begin
        wake_en_d = wake_en_q;
        if (wr_hi) begin
            wake_en_d = cfg_wdata[WAKE_ENABLE_POS];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_en_q <= 1'b0;
        end else begin
            wake_en_q <= wake_en_d;
        end
    end

    // wake drops in the cycle a clear is taken; a later event raises it again
    always_comb begin
        wake_n_d = ~(wake_status && wake_en_q && !status_clear);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_n_q <= 1'b1;
        end else begin
            wake_n_q <= wake_n_d;
        end
    end

    // bus reset returns the function to D0; a state write in the same cycle is lost
    always_comb begin
        ps_d = ps_q;
        if (bus_reset_act) begin
            ps_d = PS_D0;
        end else if (wr_lo) begin
            ps_d = lane_state(cfg_wdata);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ps_q <= PS_D0;
        end else begin
            ps_q <= ps_d;
        end
    end

    // this bank is left out of the internal D3hot-to-D0 reset; other banks take the pulse
    always_comb begin
        d0rst_d = wr_lo && !bus_reset_act && (ps_q == PS_D3HOT)
            && (lane_state(cfg_wdata) == PS_D0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            d0rst_q <= 1'b0;
        end else begin
            d0rst_q <= d0rst_d;
        end
    end

    // the bridge bits fix the D3hot action to a clock stop, so power is never removed
    always_comb begin
        clk_stop_d = d3_action(ps_d, 1'b1);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_stop_q <= 1'b0;
        end else begin
            clk_stop_q <= clk_stop_d;
        end
    end

    // kept as a flop so the output stays defined if the bridge bits ever change
    always_comb begin
        pwr_off_d = d3_action(ps_d, 1'b0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_off_q <= 1'b0;
        end else begin
            pwr_off_q <= pwr_off_d;
        end
    end

    // csr bits 14-9 and 7-2 are tied to zero, so writes cannot reach them
    assign csr_word = {wake_status, 6'h00, wake_en_q, 6'h00, ps_q};

    // read data holds until the next read, mapped or not
    always_comb begin
        rdata_d = rdata_q;
        if (cfg_rd) begin
            rdata_d = rd_hit ? read_word(csr_word) : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // every output is a flop, never a decoded term
    assign cfg_rdata = rdata_q;
    assign wake_n = wake_n_q;
    assign power_state = ps_q;
    assign sec_clock_stop = clk_stop_q;
    assign sec_power_off = pwr_off_q;
    assign d3hot_to_d0_reset = d0rst_q;
endmodule
`default_nettype wire

/* pm_ctrl_status_chk.sv */
// assertions on the power management register bank ports
`timescale 1ns/1ps
`default_nettype none
module pm_ctrl_status_chk
    import pm_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic wake_n,
    input wire logic [1:0] power_state,
    input wire logic sec_clock_stop,
    input wire logic sec_power_off,
    input wire logic d3hot_to_d0_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic sel = cfg_addr[7:2] == CSR_LO_OFFSET[7:2];
    sequence hi_wr;
        cfg_wr && sel && cfg_be[1];
    endsequence
    sequence csr_rd;
        cfg_rd && sel;
    endsequence
    ext_const_a: assert property (csr_rd |=> cfg_rdata[31:16] == 16'h00C0) else $error("fixed bytes");
    rsvd_zero_a: assert property (csr_rd |=> cfg_rdata[14:9] == 6'h0 && cfg_rdata[7:2] == 6'h0)
        else $error("reserved bits");
    state_read_a: assert property (csr_rd |=> cfg_rdata[1:0] == $past(power_state)) else $error("state read");
    state_write_a: assert property (cfg_wr && sel && cfg_be[0] |=> power_state == $past(cfg_wdata[1:0]))
        else $error("state write");
    clock_stop_a: assert property (sec_clock_stop == (power_state == PS_D3HOT)) else $error("clock stop");
    power_kept_a: assert property (!sec_power_off) else $error("power off");
    w1c_clear_a: assert property (hi_wr ##0 cfg_wdata[15] |-> ##1 wake_n) else $error("wake clear");
    wake_gate_a: assert property (hi_wr ##0 !cfg_wdata[8] |-> ##2 wake_n [*3]) else $error("wake gate");
    d0_keep_a: assert property (d3hot_to_d0_reset |-> power_state == PS_D0 ##1 !d3hot_to_d0_reset)
        else $error("d0 reset");
endmodule
bind pm_ctrl_status pm_ctrl_status_chk chk (.*);
`default_nettype wire

/* cfg_host.sv */
// configuration-space host issuing single-dword reads and writes
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    input wire logic clk,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
    // released data is inverted so a stale value can never pass for a fresh one
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(posedge clk) #1;
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, 8'hA4, be, d};
        @(posedge clk) #1;
        cfg_wr = 0;
        cfg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk) #1;
        cfg_rd = 1;
        cfg_addr = a;
        @(posedge clk) #1;
        cfg_rd = 0;
        cfg_addr = ~a;
        q = cfg_rdata;
    endtask
endmodule
`default_nettype wire

/* test_pm_ctrl_status.sv */
// self-checking bench for the power management register bank
`timescale 1ns/1ps
`default_nettype none
module test_pm_ctrl_status;
    logic clk, rst_b, bus_rst_n, ev, wr, rd, wake_n, clk_stop, pwr_off, d0_rst;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, q;
    logic [1:0] ps;
    int num_errors = 0;
    int checks = 0;
    cfg_host host (.clk(clk), .cfg_rdata(rdata), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_be(be),
        .cfg_wdata(wdata));
    pm_ctrl_status DUT (.clk(clk), .rst_b(rst_b), .pci_bus_reset_n(bus_rst_n), .cfg_wr(wr), .cfg_rd(rd),
        .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata), .wake_event(ev), .cfg_rdata(rdata), .wake_n(wake_n),
        .power_state(ps), .sec_clock_stop(clk_stop), .sec_power_off(pwr_off), .d3hot_to_d0_reset(d0_rst));
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, q);
        chk(q, e);
    endtask
    task automatic pulse_ev;
        @(posedge clk) #1 ev = 1;
        @(posedge clk) #1 ev = 0;
        repeat (3) @(posedge clk);
    endtask
    // bus reset is synchronised, so it is held and then given time to settle
    task automatic bus_reset;
        @(posedge clk) #1 bus_rst_n = 0;
        repeat (3) @(posedge clk);
        #1 bus_rst_n = 1;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_fixed;
        rc(8'hA4, 32'h00C0_0000);
        rc(8'hA8, 32'h0000_0000);
        host.wr(4'hF, 32'hFFFF_7FFF);
        rc(8'hA4, 32'h00C0_0103);
        chk({31'h0, clk_stop}, 32'h1);
        chk({31'h0, pwr_off}, 32'h0);
    endtask
    task automatic t_states;
        for (int s = 0; s < 5; s++) begin
            host.wr(4'h1, {30'h0, s[1:0]});
            // every entry to D0 in this loop comes from D3hot, so the pulse is due exactly then
            chk({30'h0, ps}, {30'h0, s[1:0]});
            chk({31'h0, d0_rst}, {31'h0, s[1:0] == 2'b00});
            chk({31'h0, clk_stop}, {31'h0, s[1:0] == 2'b11});
            rc(8'hA4, {16'h00C0, 8'h01, 6'h0, s[1:0]});
        end
    endtask
    task automatic t_wake;
        pulse_ev;
        chk({31'h0, wake_n}, 32'h0);
        host.wr(4'h2, 32'h0000_0100);
        rc(8'hA4, 32'h00C0_8100);
        host.wr(4'h2, 32'h0000_8100);
        rc(8'hA4, 32'h00C0_0100);
        chk({31'h0, wake_n}, 32'h1);
        pulse_ev;
        bus_reset;
        rc(8'hA4, 32'h00C0_8100);
        host.wr(4'h2, 32'h0000_0000);
        rc(8'hA4, 32'h00C0_8000);
        chk({31'h0, wake_n}, 32'h1);
        bus_reset;
        rc(8'hA4, 32'h00C0_0000);
        pulse_ev;
        rc(8'hA4, 32'h00C0_8000);
        chk({31'h0, wake_n}, 32'h1);
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst_b, bus_rst_n, ev} = 3'b010;
        repeat (6) @(posedge clk);
        #1 rst_b = 1;
        t_fixed;
        t_states;
        t_wake;
        give_verdict;
    end
    initial begin
        #20000;
        num_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
